/* dv/remappable_pin_select_regs_asserts.sv */
/* checker for the remap select registers: port and route relations
   assumes binding into remappable_pin_select_regs, one clock mclk */
`timescale 1ns/1ps
`default_nettype none
module remappable_pin_select_regs_asserts
  import remap_pkg::*;
#(
  parameter int NUM_PINS = 31,
  parameter int NUM_FUNCS = 32,
  parameter logic [31:0] IMPL_MASK = 32'hFFFFFFFE
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire regReq_type regReq,
  input wire logic [15:0] regRdData,
  input wire logic [NUM_PINS-1:0] pinIn,
  input wire logic [NUM_FUNCS-1:0] periphOut,
  input wire logic spiSlaveSelectInput,
  input wire logic [3:0] pinOwned,
  input wire logic [3:0] pinLevel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // write and read decodes per register index
  wire logic wr0 = regReq.wr && regReq.addr == 2'h0;
  wire logic wr1 = regReq.wr && regReq.addr == 2'h1;
  wire logic wr2 = regReq.wr && regReq.addr == 2'h2;
  wire logic rd0 = regReq.rd && regReq.addr == 2'h0;
  // both output route registers share one gap layout
  wire logic rdOut = regReq.rd && (regReq.addr == 2'h1 || regReq.addr == 2'h2);

  AST_SELECT_HIGH_ZERO: assert property (rd0 |=> regRdData[15:5] == 11'h000)
    else $error("select route upper bits not zero");
  AST_OUTPUT_GAPS_ZERO: assert property (rdOut |=> regRdData[15:13] == 3'h0 && regRdData[7:5] == 3'h0)
    else $error("output route gap bits not zero");
  AST_SELECT_READBACK: assert property (wr0 ##1 rd0 |=> regRdData[4:0] == $past(regReq.wdata[4:0], 2))
    else $error("select field readback differs");
  AST_TIED_GROUND: assert property (wr0 && regReq.wdata[4:0] == 5'h1F ##1 !wr0 |=> !spiSlaveSelectInput)
    else $error("tied select input not low");
  // route takes effect two edges after the write: field flop, then output flop
  AST_PIN0_OWNED: assert property (
    wr1 && regReq.wdata[4:0] != 5'h00 && IMPL_MASK[regReq.wdata[4:0]] ##1 !wr1 |=> pinOwned[0])
    else $error("pin 0 not taken by its function");
  AST_PIN3_OWNED: assert property (
    wr2 && regReq.wdata[12:8] != 5'h00 && IMPL_MASK[regReq.wdata[12:8]] ##1 !wr2 |=> pinOwned[3])
    else $error("pin 3 not taken by its function");
  AST_PIN2_RELEASED: assert property (
    wr2 && regReq.wdata[4:0] == 5'h00 ##1 !wr2 |=> !pinOwned[2] && !pinLevel[2])
    else $error("pin 2 still owned with function zero");
  AST_LEVEL_NEEDS_OWNER: assert property ((pinLevel & ~pinOwned) == 4'h0)
    else $error("level driven on a pin nobody owns");
endmodule : remappable_pin_select_regs_asserts

bind remappable_pin_select_regs remappable_pin_select_regs_asserts #(
  .NUM_PINS(NUM_PINS),
  .NUM_FUNCS(NUM_FUNCS),
  .IMPL_MASK(IMPL_MASK)
) asserts (
  .mclk(mclk),
  .resetn(resetn),
  .regReq(regReq),
  .regRdData(regRdData),
  .pinIn(pinIn),
  .periphOut(periphOut),
  .spiSlaveSelectInput(spiSlaveSelectInput),
  .pinOwned(pinOwned),
  .pinLevel(pinLevel)
);
`default_nettype wire

/* dv/remappable_pin_select_regs_test.sv */
/* self-checking bench for the remap select registers
   assumes design, package and remap_defines.svh compiled first */
`timescale 1ns/1ps
`default_nettype none
`include "remap_defines.svh"
module remappable_pin_select_regs_test
  import remap_pkg::*;
;
  localparam logic [31:0] implMask = `FUNC_IMPL_MASK;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  regReq_type regReq = '0;
  logic [15:0] regRdData;
  // all pins high, so a wrong route shows up as a one
  logic [30:0] pinIn = '1;
  logic [31:0] periphOut = 32'h00000000;
  logic spiSlaveSelectInput;
  logic [3:0] pinOwned;
  logic [3:0] pinLevel;
  int errorCnt = 0;
  int testsRun = 0;
  logic [4:0] funcTab [4] = '{5'h00, 5'h01, 5'h11, 5'h1F};
  logic [4:0] selTab [3] = '{5'h00, 5'h05, 5'h1E};
  logic [4:0] f [4];
  logic [3:0] ownExp;
  logic [3:0] lvlExp;
  logic [31:0] pat;

  remappable_pin_select_regs DUT (
    .mclk(mclk),
    .resetn(resetn),
    .regReq(regReq),
    .regRdData(regRdData),
    .pinIn(pinIn),
    .periphOut(periphOut),
    .spiSlaveSelectInput(spiSlaveSelectInput),
    .pinOwned(pinOwned),
    .pinLevel(pinLevel)
  );

  // 20 MHz clock
  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // strobe left up so a following access runs back to back
  task automatic writeReg(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask : writeReg

  task automatic readReg(input logic [1:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    regReq <= '0;
    #1;
    check("regRdData", regRdData, exp);
  endtask : readReg

  task automatic doReset();
    @(posedge mclk);
    regReq <= '0;
    resetn <= 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
  endtask : doReset

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finalReport

  // hang guard
  initial begin
    #2000000;
    errorCnt++;
    $display("watchdog expired");
    finalReport();
  end

  initial begin
    for (int r = 0; r < 2; r++) begin
      // second pass is a reset in mid-run over dirty registers
      doReset();
      readReg(2'h0, 16'h001F);
      readReg(2'h1, 16'h0000);
      readReg(2'h2, 16'h0000);
      check("pinOwned", {12'h000, pinOwned}, 16'h0000);
      check("spiSlaveSelectInput", {15'h0000, spiSlaveSelectInput}, 16'h0000);
      writeReg(2'h0, 16'hFFE5);
      readReg(2'h0, 16'h0005);
      writeReg(2'h1, 16'hFFFF);
      writeReg(2'h2, 16'hFFFF);
      readReg(2'h1, 16'h1F1F);
      readReg(2'h2, 16'h1F1F);
      $display("reset and field layout test done");
    end
    // read-only status index ignores writes
    writeReg(2'h3, 16'hFFFF);
    readReg(2'h1, 16'h1F1F);
    readReg(2'h3, 16'h010F);
    $display("status test done");
    for (int i = 0; i < 3; i++) begin
      writeReg(2'h0, {11'h000, selTab[i]});
      @(posedge mclk);
      regReq <= '0;
      pinIn <= 31'h1 << selTab[i];
      repeat (4) @(posedge mclk);
      #1;
      check("spiSlaveSelectInput", {15'h0000, spiSlaveSelectInput}, 16'h0001);
      @(posedge mclk);
      pinIn <= ~(31'h1 << selTab[i]);
      repeat (4) @(posedge mclk);
      #1;
      check("spiSlaveSelectInput", {15'h0000, spiSlaveSelectInput}, 16'h0000);
    end
    writeReg(2'h0, 16'h001F);
    readReg(2'h0, 16'h001F);
    repeat (3) @(posedge mclk);
    #1;
    check("spiSlaveSelectInput", {15'h0000, spiSlaveSelectInput}, 16'h0000);
    $display("input route test done");
    // every pin sees each of the four funcTab values once
    for (int i = 0; i < 4; i++) begin
      for (int p = 0; p < 4; p++) begin
        f[p] = funcTab[(p + i) % 4];
        ownExp[p] = f[p] != 5'h00 && implMask[f[p]];
      end
      pat = 32'h80020002;
      writeReg(2'h1, {3'h0, f[1], 3'h0, f[0]});
      writeReg(2'h2, {3'h0, f[3], 3'h0, f[2]});
      @(posedge mclk);
      regReq <= '0;
      periphOut <= pat;
      repeat (3) @(posedge mclk);
      #1;
      for (int p = 0; p < 4; p++) lvlExp[p] = ownExp[p] & pat[f[p]];
      check("pinOwned", {12'h000, pinOwned}, {12'h000, ownExp});
      check("pinLevel", {12'h000, pinLevel}, {12'h000, lvlExp});
      @(posedge mclk);
      periphOut <= ~pat;
      repeat (2) @(posedge mclk);
      #1;
      for (int p = 0; p < 4; p++) lvlExp[p] = ownExp[p] & ~pat[f[p]];
      check("pinLevel", {12'h000, pinLevel}, {12'h000, lvlExp});
      readReg(2'h3, {12'h000, ownExp});
    end
    $display("output route test done");
    finalReport();
  end
endmodule : remappable_pin_select_regs_test
`default_nettype wire

/* logic/pin_output_mux.sv */
/*
  Selection of one peripheral output for one remappable pin.
  Assumes the function number comes from a register on the
  same clock; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "remap_defines.svh"

module pin_output_mux
  import remap_pkg::*;
#(
  parameter int NUM_FUNCS = `NUM_FUNCS,
  parameter logic [`NUM_FUNCS-1:0] IMPL_MASK = `FUNC_IMPL_MASK
) (
  input wire routeField_type funcSel,
  input wire logic [NUM_FUNCS-1:0] periphOut,
  output pinDrive_type drive
);

  // number zero and unassigned numbers leave the pin alone
  wire logic isNone = (funcSel == `FUNC_NONE);
  wire logic inRange = (32'(funcSel) < NUM_FUNCS);
  wire logic isImpl = inRange && IMPL_MASK[funcSel];
  wire logic takes = !isNone && isImpl;

  // level is forced low when unowned to keep the mux quiet
  assign drive.owned = takes;
  assign drive.level = takes && periphOut[funcSel];

endmodule : pin_output_mux

`default_nettype wire

/* logic/remap_defines.svh */
/*
  Offsets, field positions, reset values and sizes of the
  remappable pin select registers.
  Assumes it is included by bare name, before the package.
*/
`ifndef REMAP_DEFINES_SVH
`define REMAP_DEFINES_SVH

// register index width on the plain register port
`define REG_ADDR_W 2
// data width of every register
`define REG_DATA_W 16

// register indices
`define IDX_SPI_SELECT_ROUTE 2'h0
`define IDX_PIN0_PIN1_ROUTE 2'h1
`define IDX_PIN2_PIN3_ROUTE 2'h2
`define IDX_ROUTE_STATUS 2'h3

// one route field is five bits wide
`define FIELD_W 5
// low field of a register
`define LO_FIELD_LSB 0
`define LO_FIELD_MSB 4
// high field of an output route register
`define HI_FIELD_LSB 8
`define HI_FIELD_MSB 12

// input select code that ties the input to ground
`define SS_TIED_LOW 5'h1F
// reset value of the input select field
`define SS_RESET 5'h1F
// reset value of each output function field
`define OUT_RESET 5'h00
// function number that leaves a pin to its port latch
`define FUNC_NONE 5'h00

// number of remappable pins seen by the input select
`define NUM_REMAP_PINS 31
// number of peripheral output function numbers
`define NUM_FUNCS 32
// implemented function numbers, bit n for number n
`define FUNC_IMPL_MASK 32'hFFFFFFFE
// pins with an output route field
`define NUM_OUT_PINS 4

// status register layout
`define STAT_OWN_LSB 0
`define STAT_SS_BIT 8

`endif

/* logic/remap_pkg.sv */
/*
  Types shared by the remappable pin select logic.
  Assumes remap_defines.svh is on the include path.
*/
`include "remap_defines.svh"

package remap_pkg;

  // one register port request, taken in a single cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`REG_ADDR_W-1:0] addr;
    logic [`REG_DATA_W-1:0] wdata;
  } regReq_type;

  // a five-bit route field
  typedef logic [`FIELD_W-1:0] routeField_type;

  // what the remap logic does to one output pin
  typedef struct packed {
    logic owned;
    logic level;
  } pinDrive_type;

endpackage : remap_pkg

/* logic/remappable_pin_select_regs.sv */
/*
  Remappable pin select registers: one input route for the
  SPI slave select input and the output routes of pins 0-3.
  Assumes a single 20 MHz clock mclk, an asynchronous active
  low reset, pins arriving asynchronously and peripheral
  outputs arriving from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "remap_defines.svh"

module remappable_pin_select_regs
  import remap_pkg::*;
#(
  parameter int NUM_PINS = `NUM_REMAP_PINS,
  parameter int NUM_FUNCS = `NUM_FUNCS,
  parameter logic [`NUM_FUNCS-1:0] IMPL_MASK = `FUNC_IMPL_MASK
) (
  // system clock, 20 MHz
  input wire logic mclk,
  // asynchronous reset, active low
  input wire logic resetn,
  // register port request
  input wire regReq_type regReq,
  // read data, valid the cycle after a read
  output logic [`REG_DATA_W-1:0] regRdData,
  // remappable pin levels, asynchronous
  input wire logic [NUM_PINS-1:0] pinIn,
  // peripheral output functions, by number
  input wire logic [NUM_FUNCS-1:0] periphOut,
  // routed SPI slave select input
  output logic spiSlaveSelectInput,
  // high where a peripheral owns the pin
  output logic [`NUM_OUT_PINS-1:0] pinOwned,
  // peripheral level for an owned pin
  output logic [`NUM_OUT_PINS-1:0] pinLevel
);

  // place two fields into one register image
  function automatic logic [`REG_DATA_W-1:0] packFields(
    input routeField_type hi,
    input routeField_type lo
  );
    logic [`REG_DATA_W-1:0] word;
    word = '0;
    word[`HI_FIELD_MSB:`HI_FIELD_LSB] = hi;
    word[`LO_FIELD_MSB:`LO_FIELD_LSB] = lo;
    return word;
  endfunction : packFields

  // true when the request hits a given register
  function automatic logic hits(
    input logic strobe,
    input logic [`REG_ADDR_W-1:0] addr,
    input logic [`REG_ADDR_W-1:0] idx
  );
    return strobe && (addr == idx);
  endfunction : hits

  // register state
  // input select source field
  routeField_type slaveSelectSourceField_q;
  routeField_type slaveSelectSourceField_d;
  // output function fields, one per pin
  routeField_type pin0FunctionField_q;
  routeField_type pin0FunctionField_d;
  routeField_type pin1FunctionField_q;
  routeField_type pin1FunctionField_d;
  routeField_type pin2FunctionField_q;
  routeField_type pin2FunctionField_d;
  routeField_type pin3FunctionField_q;
  routeField_type pin3FunctionField_d;

  // read data register
  logic [`REG_DATA_W-1:0] rdData_q;
  logic [`REG_DATA_W-1:0] rdData_d;

  // pin synchroniser, two stages
  logic [NUM_PINS-1:0] pinMeta_q;
  logic [NUM_PINS-1:0] pinSync_q;

  // routed outputs, registered
  logic ssIn_q;
  logic ssIn_d;
  logic [`NUM_OUT_PINS-1:0] pinOwned_q;
  logic [`NUM_OUT_PINS-1:0] pinOwned_d;
  logic [`NUM_OUT_PINS-1:0] pinLevel_q;
  logic [`NUM_OUT_PINS-1:0] pinLevel_d;

  // write decode
  wire logic wrSpiRoute = hits(regReq.wr, regReq.addr, `IDX_SPI_SELECT_ROUTE);
  wire logic wrPin01Route = hits(regReq.wr, regReq.addr, `IDX_PIN0_PIN1_ROUTE);
  wire logic wrPin23Route = hits(regReq.wr, regReq.addr, `IDX_PIN2_PIN3_ROUTE);
  // status index is read only; writes there are dropped

  // write data fields
  wire routeField_type wrLoField = regReq.wdata[`LO_FIELD_MSB:`LO_FIELD_LSB];
  wire routeField_type wrHiField = regReq.wdata[`HI_FIELD_MSB:`HI_FIELD_LSB];

  // next register values
  // only field bits are stored, so unimplemented bits stay 0
  assign slaveSelectSourceField_d = wrSpiRoute ? wrLoField
                                  : slaveSelectSourceField_q;
  assign pin0FunctionField_d = wrPin01Route ? wrLoField
                             : pin0FunctionField_q;
  assign pin1FunctionField_d = wrPin01Route ? wrHiField
                             : pin1FunctionField_q;
  assign pin2FunctionField_d = wrPin23Route ? wrLoField
                             : pin2FunctionField_q;
  assign pin3FunctionField_d = wrPin23Route ? wrHiField
                             : pin3FunctionField_q;

  // register images as software reads them
  // bits 15-5 carry nothing
  wire logic [`REG_DATA_W-1:0] spiRouteImage =
    packFields('0, slaveSelectSourceField_q);
  // bits 15-13 and 7-5 carry nothing
  wire logic [`REG_DATA_W-1:0] pin01Image =
    packFields(pin1FunctionField_q, pin0FunctionField_q);
  wire logic [`REG_DATA_W-1:0] pin23Image =
    packFields(pin3FunctionField_q, pin2FunctionField_q);

  // live state: owned pins and routed select level
  logic [`REG_DATA_W-1:0] statusImage;
  always_comb begin
    // everything else reads zero
    statusImage = '0;
    statusImage[`STAT_OWN_LSB +: `NUM_OUT_PINS] = pinOwned_q;
    statusImage[`STAT_SS_BIT] = ssIn_q;
  end

  // read selection
  logic [`REG_DATA_W-1:0] readMux;
  always_comb begin
    case (regReq.addr)
      `IDX_SPI_SELECT_ROUTE: begin
        readMux = spiRouteImage;
      end
      `IDX_PIN0_PIN1_ROUTE: begin
        readMux = pin01Image;
      end
      `IDX_PIN2_PIN3_ROUTE: begin
        readMux = pin23Image;
      end
      `IDX_ROUTE_STATUS: begin
        readMux = statusImage;
      end
      default: begin
        // all indices are mapped; kept for safety
        readMux = '0;
      end
    endcase
  end

  // data stands only in the cycle after the read
  assign rdData_d = regReq.rd ? readMux : '0;

  // input routing
  // a field beyond the pin count would index nothing
  wire logic ssTiedLow = (slaveSelectSourceField_q == `SS_TIED_LOW);
  wire logic ssInRange = (32'(slaveSelectSourceField_q) < NUM_PINS);
  wire logic ssPinLevel = ssInRange && pinSync_q[slaveSelectSourceField_q];

  // ground wins over any pin
  assign ssIn_d = ssTiedLow ? 1'b0
                : ssPinLevel;

  // output routing
  // fields gathered by pin number for the mux loop
  wire routeField_type outField [`NUM_OUT_PINS];
  assign outField[0] = pin0FunctionField_q;
  assign outField[1] = pin1FunctionField_q;
  assign outField[2] = pin2FunctionField_q;
  assign outField[3] = pin3FunctionField_q;

  // one selector per routed pin
  pinDrive_type drive [`NUM_OUT_PINS];
  for (genvar p = 0; p < `NUM_OUT_PINS; p++) begin : g_pin
    pin_output_mux #(
      .NUM_FUNCS(NUM_FUNCS),
      .IMPL_MASK(IMPL_MASK)
    ) u_mux (
      .funcSel(outField[p]),
      .periphOut(periphOut),
      .drive(drive[p])
    );
    // owned pins take the peripheral, others the port latch
    assign pinOwned_d[p] = drive[p].owned;
    assign pinLevel_d[p] = drive[p].level;
  end

  // register fields, reset to their power-on values
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slaveSelectSourceField_q <= `SS_RESET;
      pin0FunctionField_q <= `OUT_RESET;
      pin1FunctionField_q <= `OUT_RESET;
      pin2FunctionField_q <= `OUT_RESET;
      pin3FunctionField_q <= `OUT_RESET;
    end else begin
      slaveSelectSourceField_q <= slaveSelectSourceField_d;
      pin0FunctionField_q <= pin0FunctionField_d;
      pin1FunctionField_q <= pin1FunctionField_d;
      pin2FunctionField_q <= pin2FunctionField_d;
      pin3FunctionField_q <= pin3FunctionField_d;
    end
  end

  // read data register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // routed outputs; one flop of latency buys glitch-free pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ssIn_q <= 1'b0;
      pinOwned_q <= '0;
      pinLevel_q <= '0;
    end else begin
      ssIn_q <= ssIn_d;
      pinOwned_q <= pinOwned_d;
      pinLevel_q <= pinLevel_d;
    end
  end

  // outputs straight from flops
  assign regRdData = rdData_q;
  assign spiSlaveSelectInput = ssIn_q;
  assign pinOwned = pinOwned_q;
  assign pinLevel = pinLevel_q;

endmodule : remappable_pin_select_regs

`default_nettype wire
